/* File: design/acc_adc_ctrl.v */
// converter control: regulator status, modes, accumulation, result and interrupt
//
// Functional notes
// - regulator reads starting for 16 us after enable, then powered up
// - slow option makes every conversion eight times longer
// - only converter raises analogue interrupt; no comparator input here
// - conversion results are 10 bits wide
// - source selects inputs 0-5, temperature or supply; two test codes unused
// - enabling never starts; only start or accumulate start begins conversion
// - single-shot: one conversion after start, then idle
// - continuous: repeat back to back until disabled
// - accumulate start ignores single or continuous selection
// - range bit selects 0..vref or 0..2 vref span
// - temperature sensor enable independent of converter enable
// - supply monitor enable independent of converter enable
// - interrupt per single or continuous result when enabled
// - accumulation sums 2, 4, 8 or 16 conversions then stops
// - accumulation interrupt only on final sum; disable halts it
// - busy true during conversion, false on completion
// - result holds latest single result or latest accumulated sum
// - single result in low 10 bits, upper bits zero
// - accumulated result in low 14 bits
// - conversion lasts 3 x sample interval + 13 converter clocks
// - converter clock divides peripheral clock by 8, 16, 32 or 64
// ce_i low freezes all state; reset acts whether ce_i is high or low
//
// Local design decisions: register access over APB and the placing of the registers.
`include "acc_map.vh"
`default_nettype none
module acc_adc_ctrl (
    input wire clk_sys_i,
    input wire sys_rst_i,
    input wire ce_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    input wire [9:0] sample_i,
    output reg regulator_en_o,
    output reg adc_en_o,
    output reg range_double_o,
    output reg ref_sel_o,
    output reg [3:0] src_sel_o,
    output reg temp_en_o,
    output reg batt_en_o,
    output reg sample_strobe_o,
    output reg irq_o
);
    // conversion sequencer states
    localparam ST_IDLE = 2'b00;
    localparam ST_CONV = 2'b01;
    localparam [13:0] REG_CYC = `ACC_REG_START_CYC;

    reg [9:0] cfg_q;
    reg [11:0] adc_q;
    reg [13:0] reg_cnt_q;
    reg reg_up_q;
    reg [1:0] st_q;
    reg acc_mode_q;
    reg [4:0] acc_cnt_q;
    reg [5:0] tick_cnt_q;
    reg [13:0] sum_q;
    reg [15:0] result_q;
    reg done_q;
    reg [9:0] samp_m_q;
    reg [9:0] samp_q;
    wire tick;
    wire acc;
    wire wr;
    wire rd;
    wire start;
    wire acc_start;
    wire [5:0] conv_len;
    wire [4:0] acc_len;
    wire conv_end;
    wire [13:0] sum_next;

    // ticks per conversion: 3 x interval + fixed part
    function [5:0] conv_ticks;
        input [1:0] sel;
        begin
            conv_ticks = 6'd3 * ({3'b000, sel, 1'b0} + 6'd2) + 6'd`ACC_CONV_FIXED;
        end
    endfunction

    // exact register address match
    function hit;
        input [11:0] addr;
        input [11:0] reg_addr;
        begin
            hit = (addr == reg_addr);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // register bus
    // zero wait states: pready follows every setup cycle
    // reads captured in setup, shown in access
    assign acc = psel_i && penable_i && pready_o;
    assign wr = acc && pwrite_i;
    assign rd = psel_i && !penable_i && !pwrite_i;
    assign start = wr && hit(paddr_i, `ACC_REG_CMD) && pwdata_i[`ACC_CMD_START] && adc_q[`ACC_ADC_EN];
    assign acc_start = wr && hit(paddr_i, `ACC_REG_CMD) && pwdata_i[`ACC_CMD_ACC_START] && adc_q[`ACC_ADC_EN];

    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cfg_q <= 10'h000;
            adc_q <= 12'h000;
            prdata_o <= 32'h00000000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else if (ce_i) begin
            pready_o <= psel_i && !penable_i;
            // unmapped offsets answer with slave error
            pslverr_o <= psel_i && !penable_i && !(hit(paddr_i, `ACC_REG_CFG) || hit(paddr_i, `ACC_REG_ADC) ||
                hit(paddr_i, `ACC_REG_CMD) || hit(paddr_i, `ACC_REG_STAT) || hit(paddr_i, `ACC_REG_RESULT));
            // writes land at the access edge only
            if (wr && hit(paddr_i, `ACC_REG_CFG)) begin
                cfg_q <= pwdata_i[9:0];
            end
            if (wr && hit(paddr_i, `ACC_REG_ADC)) begin
                adc_q <= pwdata_i[11:0];
            end
            if (rd) begin
                case (paddr_i)
                    `ACC_REG_CFG: prdata_o <= {22'h000000, cfg_q};
                    `ACC_REG_ADC: prdata_o <= {20'h00000, adc_q};
                    `ACC_REG_STAT: prdata_o <= {29'h00000000, done_q, st_q == ST_CONV, reg_up_q};
                    `ACC_REG_RESULT: prdata_o <= {16'h0000, result_q};
                    // write-only command reads as zero
                    default: prdata_o <= 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // regulator start-up
    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            reg_cnt_q <= 14'h0000;
            reg_up_q <= 1'b0;
        end else if (ce_i) begin
            // start-up delay count
            // restarts whenever the regulator is switched off
            if (!cfg_q[`ACC_CFG_REG_EN]) begin
                reg_cnt_q <= 14'h0000;
                reg_up_q <= 1'b0;
            end else if (reg_cnt_q < REG_CYC) begin
                reg_cnt_q <= reg_cnt_q + 14'h0001;
            end else begin
                // stays set until the enable is cleared
                reg_up_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // conversion timing
    // divided converter clock
    // runs only while converting, so each conversion starts aligned
    acc_tick_gen u_tick (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .run_i(st_q == ST_CONV),
        .div_sel_i(cfg_q[`ACC_CFG_DIV_LO +: 2]),
        .slow_i(cfg_q[`ACC_CFG_SLOW]),
        .tick_o(tick)
    );

    assign conv_len = conv_ticks(cfg_q[`ACC_CFG_SAMP_LO +: 2]);
    assign acc_len = 5'd2 << adc_q[`ACC_ADC_ACC_LO +: 2];
    // last tick of the current conversion
    assign conv_end = tick && (tick_cnt_q == conv_len - 6'd1);
    // sixteen ten-bit samples fit in 14 bits
    assign sum_next = sum_q + {4'h0, samp_q};

    ////////////////////////////////////////////////////////////////////////
    // conversion state machine
    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            st_q <= ST_IDLE;
            acc_mode_q <= 1'b0;
            acc_cnt_q <= 5'h00;
            tick_cnt_q <= 6'h00;
            sum_q <= 14'h0000;
            result_q <= 16'h0000;
            done_q <= 1'b0;
            samp_m_q <= 10'h000;
            samp_q <= 10'h000;
            sample_strobe_o <= 1'b0;
            irq_o <= 1'b0;
        end else if (ce_i) begin
            // analogue input crosses domains: two stages
            samp_m_q <= sample_i;
            samp_q <= samp_m_q;
            // pulses default low, raised for one cycle below
            sample_strobe_o <= 1'b0;
            irq_o <= 1'b0;
            // disable has priority over every state
            // disable abandons work
            if (!adc_q[`ACC_ADC_EN]) begin
                st_q <= ST_IDLE;
                tick_cnt_q <= 6'h00;
                acc_cnt_q <= 5'h00;
                sum_q <= 14'h0000;
            end else begin
                case (st_q)
                    ST_IDLE: begin
                        // starts while busy are ignored
                        if (start || acc_start) begin
                            st_q <= ST_CONV;
                            acc_mode_q <= acc_start;
                            tick_cnt_q <= 6'h00;
                            acc_cnt_q <= 5'h00;
                            sum_q <= 14'h0000;
                            done_q <= 1'b0;
                        end
                    end
                    ST_CONV: begin
                        if (tick) begin
                            tick_cnt_q <= conv_end ? 6'h00 : tick_cnt_q + 6'h01;
                        end
                        if (conv_end) begin
                            sample_strobe_o <= 1'b1;
                            if (acc_mode_q) begin
                                sum_q <= sum_next;
                                acc_cnt_q <= acc_cnt_q + 5'h01;
                                if (acc_cnt_q == acc_len - 5'h01) begin
                                    result_q <= {2'b00, sum_next};
                                    done_q <= 1'b1;
                                    irq_o <= cfg_q[`ACC_CFG_INT_EN];
                                    st_q <= ST_IDLE;
                                end
                            end else begin
                                result_q <= {6'h00, samp_q};
                                done_q <= 1'b1;
                                // converter is the only interrupt source
                                irq_o <= cfg_q[`ACC_CFG_INT_EN];
                                st_q <= adc_q[`ACC_ADC_CONT] ? ST_CONV : ST_IDLE;
                            end
                        end
                    end
                    // unused codes fall back to idle
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // analogue front-end controls
    // levels follow the registers one cycle later
    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            regulator_en_o <= 1'b0;
            adc_en_o <= 1'b0;
            range_double_o <= 1'b0;
            ref_sel_o <= 1'b0;
            src_sel_o <= 4'h0;
            temp_en_o <= 1'b0;
            batt_en_o <= 1'b0;
        end else if (ce_i) begin
            regulator_en_o <= cfg_q[`ACC_CFG_REG_EN];
            adc_en_o <= adc_q[`ACC_ADC_EN];
            range_double_o <= adc_q[`ACC_ADC_RANGE];
            // reference choice passed straight through
            ref_sel_o <= cfg_q[`ACC_CFG_REF_SEL];
            src_sel_o <= adc_q[`ACC_ADC_SRC_LO +: 4];
            temp_en_o <= cfg_q[`ACC_CFG_TEMP_EN];
            batt_en_o <= cfg_q[`ACC_CFG_BATT_EN];
        end
    end
endmodule
`default_nettype wire

/* File: common/acc_map.vh */
// register map, field positions and timing counts of the converter control block
`ifndef ACC_MAP_VH
`define ACC_MAP_VH
// byte addresses on the register bus
`define ACC_REG_CFG 12'h000
`define ACC_REG_ADC 12'h004
`define ACC_REG_CMD 12'h008
`define ACC_REG_STAT 12'h00C
`define ACC_REG_RESULT 12'h010
// cfg fields
`define ACC_CFG_REG_EN 0
`define ACC_CFG_INT_EN 1
`define ACC_CFG_SAMP_LO 2
`define ACC_CFG_DIV_LO 4
`define ACC_CFG_REF_SEL 6
`define ACC_CFG_SLOW 7
`define ACC_CFG_TEMP_EN 8
`define ACC_CFG_BATT_EN 9
// adc fields
`define ACC_ADC_EN 0
`define ACC_ADC_CONT 1
`define ACC_ADC_RANGE 2
`define ACC_ADC_SRC_LO 4
`define ACC_ADC_ACC_LO 8
// cmd fields
`define ACC_CMD_START 0
`define ACC_CMD_ACC_START 1
// stat fields
`define ACC_STAT_REG_UP 0
`define ACC_STAT_BUSY 1
`define ACC_STAT_DONE 2
// source codes
`define ACC_SRC_TEMP 4'h6
`define ACC_SRC_VOLT 4'h7
`define ACC_SRC_TEST_A 4'h8
`define ACC_SRC_TEST_B 4'h9
// timing
`define ACC_REG_START_NS 16000
`define ACC_CLK_NS 40
`define ACC_REG_START_CYC ((`ACC_REG_START_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`define ACC_CONV_FIXED 13
`define ACC_SLOW_FACTOR 8
`endif

/* File: design/acc_tick_gen.v */
// converter clock tick generator: divides the peripheral clock by 8/16/32/64, or by 64/128/256/512 when slow
`default_nettype none
module acc_tick_gen (
    input wire clk_sys_i,
    input wire sys_rst_i,
    input wire ce_i,
    input wire run_i,
    input wire [1:0] div_sel_i,
    input wire slow_i,
    output reg tick_o
);
    reg [8:0] cnt_q;
    wire [8:0] last;
    // divisor 8 << sel, times eight when slow
    assign last = (slow_i ? (9'h040 << div_sel_i) : (9'h008 << div_sel_i)) - 9'h001;
    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cnt_q <= 9'h000;
            tick_o <= 1'b0;
        end else if (ce_i) begin
            if (!run_i || cnt_q >= last) begin
                cnt_q <= 9'h000;
                tick_o <= run_i;
            end else begin
                cnt_q <= cnt_q + 9'h001;
                tick_o <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/acc_adc_ctrl_properties.sv */
// port assertions of the converter control block
`include "acc_map.vh"
`default_nettype none
module acc_adc_ctrl_properties (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic regulator_en_o,
    input wire logic adc_en_o,
    input wire logic [3:0] src_sel_o,
    input wire logic sample_strobe_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] gap_q;
    logic [9:0] up_q;
    logic [31:0] cap_q;
    wire logic acc_w = psel_i && penable_i && pready_o;
    wire logic bad_w = (paddr_i > `ACC_REG_RESULT) || (paddr_i[1:0] != 2'h0);
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            gap_q <= 16'hFFFF;
            up_q <= 10'h000;
            cap_q <= 32'h0;
        end else begin
            gap_q <= sample_strobe_o ? 16'h0000 : gap_q + (gap_q != 16'hFFFF);
            up_q <= !regulator_en_o ? 10'h000 : up_q + (up_q != 10'h3FF);
            if (acc_w && pwrite_i && paddr_i == `ACC_REG_ADC)
                cap_q <= pwdata_i;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    sequence setup_s;
        psel_i && !penable_i;
    endsequence
    sequence stat_rd_s;
        acc_w && !pwrite_i && paddr_i == `ACC_REG_STAT;
    endsequence
    pready_a: assert property (setup_s |=> pready_o) else $error("pready late");
    bad_addr_a: assert property (setup_s |=> pslverr_o == $past(bad_w)) else $error("pslverr wrong");
    adc_mirror_a: assert property (acc_w && pwrite_i && paddr_i == `ACC_REG_ADC |-> ##[1:2]
        (adc_en_o == cap_q[0] && src_sel_o == cap_q[7:4])) else $error("adc config not mirrored");
    irq_cause_a: assert property (irq_o |-> sample_strobe_o) else $error("irq without result");
    irq_pulse_a: assert property (irq_o |=> !irq_o) else $error("irq too long");
    idle_quiet_a: assert property (!adc_en_o && $past(!adc_en_o) |-> !sample_strobe_o) else $error("conv disabled");
    conv_gap_a: assert property (sample_strobe_o |-> gap_q >= 16'd151) else $error("conversion short");
    reg_early_a: assert property (stat_rd_s ##0 (up_q < 10'd398) |-> !prdata_o[0]) else $error("regulator early");
    reg_late_a: assert property (stat_rd_s ##0 (up_q > 10'd402) |-> prdata_o[0]) else $error("regulator late");
    result_width_a: assert property (acc_w && !pwrite_i && paddr_i == `ACC_REG_RESULT
        |-> prdata_o[31:14] == 18'h0) else $error("result high bits set");
endmodule
`default_nettype wire

/* File: tb/acc_afe_model.sv */
// analogue front end model: steady level while the converter is on
`default_nettype none
module acc_afe_model (
    input wire logic clk_sys_i,
    input wire logic adc_en_i,
    input wire logic [9:0] level_i,
    output logic [9:0] sample_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial sample_o = 10'h155;
    // powered-down output toggles so stale data never matches
    always @(posedge clk_sys_i) begin
        sample_o <= adc_en_i ? level_i : ~sample_o;
    end
endmodule
`default_nettype wire

/* File: tb/acc_adc_ctrl_tb.sv */
// self-checking testbench of the converter control block
`include "acc_map.vh"
`default_nettype none
module acc_adc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 0;
    logic sys_rst_i = 1;
    logic psel = 0, penable = 0, pwrite = 0, err, ce = 1;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rdat;
    logic [9:0] level = 0;
    wire logic [9:0] sample;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, reg_en, adc_en, rng, rsel, temp_en, batt_en, strobe, irq;
    wire logic [3:0] src;
    integer fails = 0, num_checks = 0, seed = 32'h62c4, n_str = 0, n_irq = 0, cyc = 0, i, t0, s0, q0;
    acc_adc_ctrl i_acc_adc_ctrl (.clk_sys_i, .sys_rst_i, .ce_i(ce), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .sample_i(sample), .regulator_en_o(reg_en), .adc_en_o(adc_en),
        .range_double_o(rng), .ref_sel_o(rsel), .src_sel_o(src), .temp_en_o(temp_en),
        .batt_en_o(batt_en), .sample_strobe_o(strobe), .irq_o(irq));
    acc_afe_model i_acc_afe_model (.clk_sys_i, .adc_en_i(adc_en), .level_i(level), .sample_o(sample));
    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        n_str <= n_str + (strobe === 1'b1);
        n_irq <= n_irq + (irq === 1'b1);
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do @(negedge clk_sys_i); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        @(posedge clk_sys_i);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic idle_wait();
        rdat = 32'h2;
        for (int k = 0; k < 3000 && rdat[1] !== 1'b0; k++) apb(0, `ACC_REG_STAT, 0);
    endtask
    function automatic logic [31:0] adcw(logic e, logic r, logic c, logic [3:0] s, logic [1:0] n);
        return {22'h0, n, s, 1'b0, r, c, e};
    endfunction
    task automatic end_sim();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #(40 * 40000);
        fails++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        apb(1, `ACC_REG_CFG, 32'h3);
        apb(0, `ACC_REG_STAT, 0);
        chk(rdat[0], 0);
        apb(0, 12'h014, 0);
        chk(err, 1);
        chk(rdat, 0);
        repeat (400) @(posedge clk_sys_i);
        apb(0, `ACC_REG_STAT, 0);
        chk(rdat[0], 1);
        $display("test regulator done");
        for (i = 0; i < 10; i++) begin
            apb(1, `ACC_REG_ADC, adcw(i[2], i[0], i[0], i[3:0], 0));
            apb(1, `ACC_REG_CFG, {22'h0, i[1], i[0], 8'h03});
            repeat (2) @(posedge clk_sys_i);
            chk({adc_en, temp_en, batt_en, rng, src}, {i[2], i[0], i[1], i[0], i[3:0]});
        end
        chk(n_str, 0);
        $display("test config done");
        for (i = 0; i < 5; i++) begin
            level <= $random(seed);
            apb(1, `ACC_REG_CFG, {24'h0, i == 4, 5'h0, i < 3, 1'b1});
            apb(1, `ACC_REG_ADC, adcw(1, i[0], 0, i[3:0], 0));
            t0 = cyc;
            s0 = n_str;
            q0 = n_irq;
            apb(1, `ACC_REG_CMD, 32'h1);
            idle_wait();
            chk(i == 4 ? (cyc - t0 > 1150 && cyc - t0 < 1300) : (cyc - t0 > 143 && cyc - t0 < 200), 1);
            apb(0, `ACC_REG_RESULT, 0);
            chk(rdat, {22'h0, level});
            chk(n_irq - q0, i < 3);
            repeat (300) @(posedge clk_sys_i);
            chk(n_str - s0, 1);
        end
        apb(1, `ACC_REG_CFG, 32'h3);
        $display("test single done");
        for (i = 0; i < 4; i++) begin
            level <= $random(seed);
            apb(1, `ACC_REG_ADC, adcw(1, 0, 1, 5, i[1:0]));
            s0 = n_str;
            q0 = n_irq;
            apb(1, `ACC_REG_CMD, 32'h2);
            idle_wait();
            apb(0, `ACC_REG_RESULT, 0);
            chk(rdat, level * (2 << i));
            chk(n_irq - q0, 1);
            repeat (300) @(posedge clk_sys_i);
            chk(n_str - s0, 2 << i);
        end
        $display("test accumulate done");
        level <= $random(seed);
        apb(1, `ACC_REG_ADC, adcw(1, 0, 1, 2, 0));
        s0 = n_str;
        apb(1, `ACC_REG_CMD, 32'h1);
        ce <= 1'b0;
        q0 = n_str;
        repeat (400) @(posedge clk_sys_i);
        chk(n_str - q0, 0);
        ce <= 1'b1;
        repeat (500) @(posedge clk_sys_i);
        apb(0, `ACC_REG_STAT, 0);
        chk(rdat[1], 1);
        apb(1, `ACC_REG_ADC, adcw(0, 0, 1, 2, 0));
        chk(n_str - s0 >= 3, 1);
        repeat (2) @(posedge clk_sys_i);
        s0 = n_str;
        repeat (400) @(posedge clk_sys_i);
        chk(n_str - s0, 0);
        apb(1, `ACC_REG_ADC, adcw(1, 0, 1, 2, 3));
        apb(1, `ACC_REG_CMD, 32'h2);
        repeat (400) @(posedge clk_sys_i);
        apb(1, `ACC_REG_ADC, adcw(0, 0, 1, 2, 3));
        apb(0, `ACC_REG_STAT, 0);
        chk(rdat[1], 0);
        apb(0, `ACC_REG_RESULT, 0);
        chk(rdat, {22'h0, level});
        $display("test disable done");
        end_sim();
    end
endmodule
bind acc_adc_ctrl acc_adc_ctrl_properties i_acc_adc_ctrl_properties (.clk_sys_i, .sys_rst_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .regulator_en_o, .adc_en_o, .src_sel_o,
    .sample_strobe_o, .irq_o);
`default_nettype wire
